// *** actocf_top.v ***
// Purpose: offset and gain trim, fast filter overcurrent comparator and fault pin of one
//          current-sense channel, with an AHB-Lite register slave
// Assumes: modulator and raw conversion inputs are synchronous to CLK_I
// Notes:   single-cycle slave, never stalls, always answers OKAY
//
// Contract
// - offset high register holds trim bits 23:8
// - offset low holds bits 7:0, low byte zero
// - offset step is 2*vref/(gain*2^24)
// - gain factor is one plus value/65536
// - enable bit gates filter and comparator together
// - fast filter ignores conversion start and stop
// - fast filter is third_order_sinc_filter with ratio 64
// - polarity bit selects fault pin active level
// - fault active while any trip flag active
// - shared pin shows fault only when selected
// - trip after selected run of beyond results
// - counter restarts when result returns inside
// - deglitch codes map to counts, max 128
// - config bits 7:0 read as zero
// - above high threshold counts, 7FFF disables
// - below low threshold counts, 8000 disables
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "actocf_map.vh"

module actocf_top (
    input  wire        CLK_I,
    input  wire        RSTN_I,
    input  wire        HSEL_I,
    input  wire [31:0] HADDR_I,
    input  wire [1:0]  HTRANS_I,
    input  wire        HWRITE_I,
    input  wire [2:0]  HSIZE_I,
    input  wire [31:0] HWDATA_I,
    input  wire        HREADY_I,
    output reg  [31:0] HRDATA_O,
    output reg         HREADYOUT_O,
    output reg         HRESP_O,
    input  wire        MOD_STB_I,
    input  wire        MOD_BIT_I,
    input  wire        RAW_VLD_I,
    input  wire [23:0] RAW_DATA_I,
    output reg         CAL_VLD_O,
    output reg  [23:0] CAL_DATA_O,
    output reg         FAULT_OUTPUT_PIN_O,
    output reg         SHARED_PIN_O,
    output reg         SHARED_PIN_OE_O,
    output reg         IRQ_O
);

    // ------------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------------
    reg rst_meta_q;
    reg rst_n_q;

    // others reset on rst_n_q
    always @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    reg  [15:0] offset_trim_high_q;
    reg  [7:0]  offset_trim_low_q;
    reg  [15:0] gain_trim_value_q;
    reg         comparator_enable_q;
    reg         fault_pin_polarity_q;
    reg         cfg_rsv_q;
    reg  [4:0]  deglitch_count_select_q;
    reg  [15:0] thr_high_q;
    reg  [15:0] thr_low_q;
    reg  [1:0]  stat_q;
    reg  [1:0]  mask_q;
    reg  [2:0]  pinctl_q;

    // ------------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------------
    reg         wr_pend_q;
    reg  [7:0]  wr_idx_q;
    wire        acc_ok;
    wire [7:0]  acc_idx;
    reg  [31:0] rd_mux;
    wire        wr_ofs_hi;
    wire        wr_ofs_lo;
    wire        wr_gain;
    wire        wr_cfg;
    wire        wr_thr_hi;
    wire        wr_thr_lo;
    wire        wr_stat;
    wire        wr_mask;
    wire        wr_pin;

    assign acc_ok  = HSEL_I && HREADY_I && HTRANS_I[1];
    assign acc_idx = HADDR_I[9:2];

    // writes land one edge late
    assign wr_ofs_hi = wr_pend_q && (wr_idx_q == `ACTOCF_IDX_OFS_HI);
    assign wr_ofs_lo = wr_pend_q && (wr_idx_q == `ACTOCF_IDX_OFS_LO);
    assign wr_gain   = wr_pend_q && (wr_idx_q == `ACTOCF_IDX_GAIN);
    assign wr_cfg    = wr_pend_q && (wr_idx_q == `ACTOCF_IDX_CFG);
    assign wr_thr_hi = wr_pend_q && (wr_idx_q == `ACTOCF_IDX_THR_HI);
    assign wr_thr_lo = wr_pend_q && (wr_idx_q == `ACTOCF_IDX_THR_LO);
    assign wr_stat   = wr_pend_q && (wr_idx_q == `ACTOCF_IDX_STAT);
    assign wr_mask   = wr_pend_q && (wr_idx_q == `ACTOCF_IDX_MASK);
    assign wr_pin    = wr_pend_q && (wr_idx_q == `ACTOCF_IDX_PINCTL);

    // unmapped indices read zero and ignore writes
    always @* begin
        rd_mux = 32'h00000000;
        case (acc_idx)
            `ACTOCF_IDX_OFS_HI: rd_mux[15:0] = offset_trim_high_q;
            `ACTOCF_IDX_OFS_LO: rd_mux[15:8] = offset_trim_low_q;
            `ACTOCF_IDX_GAIN:   rd_mux[15:0] = gain_trim_value_q;
            `ACTOCF_IDX_CFG:    rd_mux[15:8] = {comparator_enable_q, fault_pin_polarity_q,
                                                cfg_rsv_q, deglitch_count_select_q};
            `ACTOCF_IDX_THR_HI: rd_mux[15:0] = thr_high_q;
            `ACTOCF_IDX_THR_LO: rd_mux[15:0] = thr_low_q;
            `ACTOCF_IDX_STAT:   rd_mux[1:0]  = stat_q;
            `ACTOCF_IDX_MASK:   rd_mux[1:0]  = mask_q;
            `ACTOCF_IDX_PINCTL: rd_mux[2:0]  = pinctl_q;
            default:            rd_mux       = 32'h00000000;
        endcase
    end

    always @(posedge CLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wr_pend_q   <= 1'b0;
            wr_idx_q    <= 8'h00;
            HRDATA_O    <= 32'h00000000;
            HREADYOUT_O <= 1'b0;
            HRESP_O     <= 1'b0;
        end else begin
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
            wr_pend_q   <= acc_ok && HWRITE_I;
            if (acc_ok) begin
                wr_idx_q <= acc_idx;
            end
            if (acc_ok && !HWRITE_I) begin
                HRDATA_O <= rd_mux;
            end
        end
    end

    always @(posedge CLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            offset_trim_high_q      <= `ACTOCF_RST_OFS_HI;
            offset_trim_low_q       <= `ACTOCF_RST_OFS_LO;
            gain_trim_value_q       <= `ACTOCF_RST_GAIN;
            {comparator_enable_q, fault_pin_polarity_q, cfg_rsv_q,
             deglitch_count_select_q} <= `ACTOCF_RST_CFG;
            thr_high_q              <= `ACTOCF_RST_THR_HI;
            thr_low_q               <= `ACTOCF_RST_THR_LO;
            mask_q                  <= `ACTOCF_RST_MASK;
            pinctl_q                <= `ACTOCF_RST_PINCTL;
        end else begin
            if (wr_ofs_hi) begin
                offset_trim_high_q <= HWDATA_I[15:0];
            end
            if (wr_ofs_lo) begin
                offset_trim_low_q <= HWDATA_I[`ACTOCF_OFS_LO_HI:`ACTOCF_OFS_LO_LO];
            end
            if (wr_gain) begin
                gain_trim_value_q <= HWDATA_I[15:0];
            end
            if (wr_cfg) begin
                comparator_enable_q     <= HWDATA_I[`ACTOCF_CFG_EN_BIT];
                fault_pin_polarity_q    <= HWDATA_I[`ACTOCF_CFG_POL_BIT];
                // stored as written; software is expected to keep it zero
                cfg_rsv_q               <= HWDATA_I[`ACTOCF_CFG_RSV_BIT];
                deglitch_count_select_q <= HWDATA_I[`ACTOCF_CFG_NUM_HI:`ACTOCF_CFG_NUM_LO];
            end
            if (wr_thr_hi) begin
                thr_high_q <= HWDATA_I[15:0];
            end
            if (wr_thr_lo) begin
                thr_low_q <= HWDATA_I[15:0];
            end
            if (wr_mask) begin
                mask_q <= HWDATA_I[1:0];
            end
            if (wr_pin) begin
                pinctl_q <= HWDATA_I[2:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // deglitch count decode
    // ------------------------------------------------------------------------
    reg [7:0] need_cnt;

    // steps of 2 past code 9 up to code 18, one of 4 to code 19, then of 8
    always @* begin
        need_cnt = 8'h00;
        case (deglitch_count_select_q)
            5'h12:   need_cnt = 8'h1C;
            5'h13:   need_cnt = 8'h20;
            default: begin
                if (deglitch_count_select_q < 5'h0A) begin
                    need_cnt = {3'h0, deglitch_count_select_q} + 8'h01;
                end else if (deglitch_count_select_q < 5'h12) begin
                    need_cnt = {2'h0, deglitch_count_select_q, 1'b0} - 8'h08;
                end else begin
                    need_cnt = {deglitch_count_select_q, 3'h0} - 8'h78;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // fast filter and comparator
    // ------------------------------------------------------------------------
    wire        ff_vld;
    wire [15:0] ff_val;
    wire        cmp_clr;
    wire [1:0]  beyond;
    wire [1:0]  trip;

    // only the enable bit clears the path; start and stop never reach it
    assign cmp_clr = !comparator_enable_q;

    actocf_third_order_sinc_filter u_ff (
        .clk_i     (CLK_I),
        .rst_n_i   (rst_n_q),
        .clr_i     (cmp_clr),
        .mod_stb_i (MOD_STB_I),
        .mod_bit_i (MOD_BIT_I),
        .out_vld_o (ff_vld),
        .out_val_o (ff_val)
    );

    // a strict compare makes the full-scale settings unreachable, so they disable
    assign beyond[`ACTOCF_STAT_HT_BIT] = $signed(ff_val) > $signed(thr_high_q);
    assign beyond[`ACTOCF_STAT_LT_BIT] = $signed(ff_val) < $signed(thr_low_q);

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_dir
            actocf_degl u_degl (
                .clk_i    (CLK_I),
                .rst_n_i  (rst_n_q),
                .clr_i    (cmp_clr),
                .stb_i    (ff_vld),
                .beyond_i (beyond[gi]),
                .need_i   (need_cnt),
                .trip_o   (trip[gi])
            );
        end
    endgenerate

    // trip flags: sticky, write one to clear, a new trip wins over the clear
    always @(posedge CLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            stat_q <= `ACTOCF_RST_STAT;
        end else begin
            stat_q <= (stat_q & ~(wr_stat ? HWDATA_I[1:0] : 2'h0)) | trip;
        end
    end

    // ------------------------------------------------------------------------
    // fault pin, shared pin and interrupt
    // ------------------------------------------------------------------------
    wire fault_act;
    wire fault_lvl;
    wire shared_lvl;

    assign fault_act  = |stat_q;
    assign fault_lvl  = fault_pin_polarity_q ? fault_act : !fault_act;
    assign shared_lvl = pinctl_q[`ACTOCF_PIN_SRC_BIT] ? fault_lvl
                                                      : pinctl_q[`ACTOCF_PIN_GPO_BIT];

    always @(posedge CLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            FAULT_OUTPUT_PIN_O <= 1'b1;
            // released pin rests high
            SHARED_PIN_O       <= 1'b1;
            SHARED_PIN_OE_O    <= 1'b0;
            IRQ_O              <= 1'b0;
        end else begin
            // pins follow status one edge late
            FAULT_OUTPUT_PIN_O <= fault_lvl;
            // open-drain format drives only the low level
            SHARED_PIN_O       <= shared_lvl;
            SHARED_PIN_OE_O    <= !pinctl_q[`ACTOCF_PIN_FMT_BIT] || !shared_lvl;
            IRQ_O              <= |(stat_q & mask_q);
        end
    end

    // ------------------------------------------------------------------------
    // calibration
    // ------------------------------------------------------------------------
    // trim step in volts is set by the analog reference and gain, not here

    wire signed [24:0] cal_diff;
    wire signed [17:0] cal_fac;
    wire signed [42:0] cal_prod;
    wire signed [26:0] cal_shift;

    assign cal_diff  = $signed({RAW_DATA_I[23], RAW_DATA_I})
                     - $signed({offset_trim_high_q[15], offset_trim_high_q,
                                offset_trim_low_q});
    assign cal_fac   = $signed(`ACTOCF_GAIN_UNITY)
                     + $signed({{2{gain_trim_value_q[15]}}, gain_trim_value_q});

    // 25x18 bits fit in 43
    assign cal_prod  = cal_diff * cal_fac;
    assign cal_shift = cal_prod[42:16];

    always @(posedge CLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            CAL_VLD_O  <= 1'b0;
            CAL_DATA_O <= 24'h000000;
        end else begin
            CAL_VLD_O <= RAW_VLD_I;
            if (RAW_VLD_I) begin
                if (cal_shift > $signed({3'h0, `ACTOCF_CAL_MAX})) begin
                    CAL_DATA_O <= `ACTOCF_CAL_MAX;
                end else if (cal_shift < $signed({3'h7, `ACTOCF_CAL_MIN})) begin
                    CAL_DATA_O <= `ACTOCF_CAL_MIN;
                end else begin
                    CAL_DATA_O <= cal_shift[23:0];
                end
            end
        end
    end

endmodule // actocf_top

// *** actocf_map.vh ***
// Purpose: register indices, field positions, reset values and fast filter and calibration constants of the
//          current-sense channel trim and overcurrent comparator block
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef ACTOCF_MAP_VH
`define ACTOCF_MAP_VH

// ----------------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------------
`define ACTOCF_IDX_OFS_HI     8'hC4
`define ACTOCF_IDX_OFS_LO     8'hC5
`define ACTOCF_IDX_GAIN       8'hC6
`define ACTOCF_IDX_CFG        8'hC7
`define ACTOCF_IDX_THR_HI     8'hC8
`define ACTOCF_IDX_THR_LO     8'hC9
`define ACTOCF_IDX_STAT       8'hD0
`define ACTOCF_IDX_MASK       8'hD1
`define ACTOCF_IDX_PINCTL     8'hD2

// ----------------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------------
`define ACTOCF_CFG_EN_BIT     15
`define ACTOCF_CFG_POL_BIT    14
`define ACTOCF_CFG_RSV_BIT    13
`define ACTOCF_CFG_NUM_HI     12
`define ACTOCF_CFG_NUM_LO     8
`define ACTOCF_OFS_LO_HI      15
`define ACTOCF_OFS_LO_LO      8
`define ACTOCF_STAT_HT_BIT    0
`define ACTOCF_STAT_LT_BIT    1
`define ACTOCF_PIN_SRC_BIT    0
`define ACTOCF_PIN_FMT_BIT    1
`define ACTOCF_PIN_GPO_BIT    2

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define ACTOCF_RST_OFS_HI     16'h0000
`define ACTOCF_RST_OFS_LO     8'h00
`define ACTOCF_RST_GAIN       16'h0000
`define ACTOCF_RST_CFG        8'h00
`define ACTOCF_RST_THR_HI     16'h7FFF
`define ACTOCF_RST_THR_LO     16'h8000
`define ACTOCF_RST_STAT       2'h0
`define ACTOCF_RST_MASK       2'h0
`define ACTOCF_RST_PINCTL     3'h0

// ----------------------------------------------------------------------------
// fast filter and calibration constants
// ----------------------------------------------------------------------------
`define ACTOCF_FF_OSR_LOG2    6
`define ACTOCF_FF_ACC_W       21
`define ACTOCF_FF_SHIFT       3
`define ACTOCF_GAIN_UNITY     18'h10000
`define ACTOCF_CAL_MAX        24'h7FFFFF
`define ACTOCF_CAL_MIN        24'h800000

`endif

// *** actocf_third_order_sinc_filter.v ***
// Purpose: third-order sinc decimator with a fixed oversampling ratio of 64
// Assumes: one modulator bit per strobe, bit 1 means +1 and bit 0 means -1
// Notes:   output is the comb result divided by 8, saturated to signed 16 bits
`timescale 1ns/1ns
`include "actocf_map.vh"

module actocf_third_order_sinc_filter (
    input  wire        clk_i,
    input  wire        rst_n_i,
    input  wire        clr_i,
    input  wire        mod_stb_i,
    input  wire        mod_bit_i,
    output reg         out_vld_o,
    output reg  [15:0] out_val_o
);

    localparam AW = `ACTOCF_FF_ACC_W;

    reg  signed [AW-1:0] int1_q;
    reg  signed [AW-1:0] int2_q;
    reg  signed [AW-1:0] int3_q;
    reg  signed [AW-1:0] dly1_q;
    reg  signed [AW-1:0] dly2_q;
    reg  signed [AW-1:0] dly3_q;
    reg  [`ACTOCF_FF_OSR_LOG2-1:0] dec_cnt_q;
    wire signed [AW-1:0] inc;
    wire signed [AW-1:0] cmb1;
    wire signed [AW-1:0] cmb2;
    wire signed [AW-1:0] cmb3;
    wire signed [AW-1:0] scaled;
    wire                 dec_tick;

    assign inc      = mod_bit_i ? {{(AW-1){1'b0}}, 1'b1} : {AW{1'b1}};
    assign dec_tick = mod_stb_i && (dec_cnt_q == {`ACTOCF_FF_OSR_LOG2{1'b1}});
    // wraparound in the integrators is harmless: the combs undo it
    assign cmb1     = int3_q - dly1_q;
    assign cmb2     = cmb1 - dly2_q;
    assign cmb3     = cmb2 - dly3_q;
    assign scaled   = cmb3 >>> `ACTOCF_FF_SHIFT;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int1_q    <= {AW{1'b0}};
            int2_q    <= {AW{1'b0}};
            int3_q    <= {AW{1'b0}};
            dly1_q    <= {AW{1'b0}};
            dly2_q    <= {AW{1'b0}};
            dly3_q    <= {AW{1'b0}};
            dec_cnt_q <= {`ACTOCF_FF_OSR_LOG2{1'b0}};
            out_vld_o <= 1'b0;
            out_val_o <= 16'h0000;
        end else if (clr_i) begin
            int1_q    <= {AW{1'b0}};
            int2_q    <= {AW{1'b0}};
            int3_q    <= {AW{1'b0}};
            dly1_q    <= {AW{1'b0}};
            dly2_q    <= {AW{1'b0}};
            dly3_q    <= {AW{1'b0}};
            dec_cnt_q <= {`ACTOCF_FF_OSR_LOG2{1'b0}};
            out_vld_o <= 1'b0;
            out_val_o <= 16'h0000;
        end else begin
            out_vld_o <= dec_tick;
            if (mod_stb_i) begin
                int1_q    <= int1_q + inc;
                int2_q    <= int2_q + int1_q;
                int3_q    <= int3_q + int2_q;
                dec_cnt_q <= dec_cnt_q + 1'b1;
            end
            if (dec_tick) begin
                dly1_q <= int3_q;
                dly2_q <= cmb1;
                dly3_q <= cmb2;
                if (scaled > $signed({{(AW-16){1'b0}}, 16'h7FFF})) begin
                    out_val_o <= 16'h7FFF;
                end else if (scaled < $signed({{(AW-16){1'b1}}, 16'h8000})) begin
                    out_val_o <= 16'h8000;
                end else begin
                    out_val_o <= scaled[15:0];
                end
            end
        end
    end

endmodule // actocf_third_order_sinc_filter

// *** actocf_degl.v ***
// Purpose: deglitch counter for one threshold direction
// Assumes: stb_i marks one fast filter result, beyond_i qualifies it
// Notes:   trip_o pulses on each beyond result once the run reaches need_i
`timescale 1ns/1ns

module actocf_degl (
    input  wire       clk_i,
    input  wire       rst_n_i,
    input  wire       clr_i,
    input  wire       stb_i,
    input  wire       beyond_i,
    input  wire [7:0] need_i,
    output reg        trip_o
);

    reg [7:0] run_q;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_q  <= 8'h00;
            trip_o <= 1'b0;
        end else if (clr_i) begin
            run_q  <= 8'h00;
            trip_o <= 1'b0;
        end else begin
            trip_o <= stb_i && beyond_i && (run_q >= need_i - 8'h01);
            if (stb_i) begin
                if (!beyond_i) begin
                    run_q <= 8'h00;
                end else if (run_q != 8'hFF) begin
                    run_q <= run_q + 8'h01;
                end
            end
        end
    end

endmodule // actocf_degl

// *** actocf_top_chk.sv ***
// Purpose: port-level checks of the trim and overcurrent block
// Assumes: bus hready is tied to HREADYOUT_O
// Notes:   fault pin and irq may only move shortly after a strobe or a bus access
`timescale 1ns/1ns
`include "actocf_map.vh"

module actocf_top_chk (
    input wire        CLK_I,
    input wire        RSTN_I,
    input wire        HSEL_I,
    input wire [31:0] HADDR_I,
    input wire [1:0]  HTRANS_I,
    input wire        HWRITE_I,
    input wire [31:0] HRDATA_O,
    input wire        HREADYOUT_O,
    input wire        HRESP_O,
    input wire        MOD_STB_I,
    input wire        RAW_VLD_I,
    input wire        CAL_VLD_O,
    input wire        FAULT_OUTPUT_PIN_O,
    input wire        SHARED_PIN_O,
    input wire        SHARED_PIN_OE_O,
    input wire        IRQ_O
);
    logic [3:0] quiet_q;
    wire        take = HSEL_I && HTRANS_I[1] && HREADYOUT_O;

    // ----------------------------------------------------------------
    // idle counter: saturates so a long quiet spell stays quiet
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) quiet_q <= 4'h0;
        else if (take || MOD_STB_I) quiet_q <= 4'h0;
        else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
    end

    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    sequence s_rd(logic [7:0] ix);
        take && !HWRITE_I && HADDR_I[9:2] == ix;
    endsequence

    property p_cal_resp; RAW_VLD_I |=> CAL_VLD_O; endproperty
    a_cal_resp: assert property (p_cal_resp) else $error("no result after raw");
    property p_cal_pulse; !RAW_VLD_I |=> !CAL_VLD_O; endproperty
    a_cal_pulse: assert property (p_cal_pulse) else $error("stray result");
    property p_cfg_rsv; s_rd(`ACTOCF_IDX_CFG) |=> HRDATA_O[7:0] == 8'h00; endproperty
    a_cfg_rsv: assert property (p_cfg_rsv) else $error("config low byte set");
    property p_ofl_rsv; s_rd(`ACTOCF_IDX_OFS_LO) |=> HRDATA_O[7:0] == 8'h00; endproperty
    a_ofl_rsv: assert property (p_ofl_rsv) else $error("offset low byte set");
    property p_od_high; !SHARED_PIN_OE_O |-> SHARED_PIN_O; endproperty
    a_od_high: assert property (p_od_high) else $error("released pin not high");
    property p_quiet; quiet_q >= 4'hC |-> $stable(FAULT_OUTPUT_PIN_O) && $stable(IRQ_O); endproperty
    a_quiet: assert property (p_quiet) else $error("fault moved while idle");
    property p_rd_hold; !(take && !HWRITE_I) |=> $stable(HRDATA_O); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_ready; HREADYOUT_O |=> HREADYOUT_O && !HRESP_O; endproperty
    a_ready: assert property (p_ready) else $error("slave stalled or erred");
endmodule // actocf_top_chk

bind actocf_top actocf_top_chk actocf_top_chk_inst (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
    .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HRDATA_O(HRDATA_O),
    .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .MOD_STB_I(MOD_STB_I),
    .RAW_VLD_I(RAW_VLD_I), .CAL_VLD_O(CAL_VLD_O), .FAULT_OUTPUT_PIN_O(FAULT_OUTPUT_PIN_O),
    .SHARED_PIN_O(SHARED_PIN_O), .SHARED_PIN_OE_O(SHARED_PIN_OE_O), .IRQ_O(IRQ_O));

// *** actocf_top_tb.sv ***
// Purpose: self-checking bench of the trim and overcurrent block
// Assumes: zero-wait slave, hready looped back from HREADYOUT_O
// Notes:   expectations are queued by the driver and checked by a monitor
`timescale 1ns/1ns
`include "actocf_map.vh"

module actocf_top_tb;
    logic        CLK_I = 0, RSTN_I = 0, HSEL_I = 0, HWRITE_I = 0;
    logic        MOD_STB_I = 0, MOD_BIT_I = 0, RAW_VLD_I = 0, rd_ph = 0, pin_pr = 0;
    logic [31:0] HADDR_I = 0, HWDATA_I = 0;
    logic [1:0]  HTRANS_I = 0;
    logic [23:0] RAW_DATA_I = 0;
    wire  [31:0] HRDATA_O;
    wire  [23:0] CAL_DATA_O;
    wire         HREADYOUT_O, HRESP_O, CAL_VLD_O, FAULT_OUTPUT_PIN_O;
    wire         SHARED_PIN_O, SHARED_PIN_OE_O, IRQ_O;
    logic [31:0] q_rd[$];
    logic [23:0] q_cal[$];
    logic [3:0]  q_pin[$];
    int          fail_count = 0, check_count = 0, cyc = 0;

    actocf_top actocf_top_inst (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .HSEL_I(HSEL_I),
        .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(3'h2),
        .HWDATA_I(HWDATA_I), .HREADY_I(HREADYOUT_O), .HRDATA_O(HRDATA_O),
        .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .MOD_STB_I(MOD_STB_I),
        .MOD_BIT_I(MOD_BIT_I), .RAW_VLD_I(RAW_VLD_I), .RAW_DATA_I(RAW_DATA_I),
        .CAL_VLD_O(CAL_VLD_O), .CAL_DATA_O(CAL_DATA_O), .FAULT_OUTPUT_PIN_O(FAULT_OUTPUT_PIN_O),
        .SHARED_PIN_O(SHARED_PIN_O), .SHARED_PIN_OE_O(SHARED_PIN_OE_O), .IRQ_O(IRQ_O));

    always #5 CLK_I = ~CLK_I;

    task close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // monitor and hang guard
    // ----------------------------------------------------------------
    task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    always @(posedge CLK_I) begin
        cyc++;
        if (cyc == 10000) begin
            fail_count++;
            close_out;
        end
        if (rd_ph && HREADYOUT_O) cmp("hrdata", q_rd.pop_front(), HRDATA_O);
        if (CAL_VLD_O) cmp("cal", {8'h00, q_cal.pop_front()}, {8'h00, CAL_DATA_O});
        if (pin_pr) cmp("pins", {28'h0, q_pin.pop_front()},
            {28'h0, FAULT_OUTPUT_PIN_O, SHARED_PIN_O, SHARED_PIN_OE_O, IRQ_O});
    end

    // ----------------------------------------------------------------
    // drivers
    // ----------------------------------------------------------------
    task ahb(input logic w, input logic [7:0] ix, input logic [31:0] d, input logic [31:0] e);
        HSEL_I <= 1;
        HADDR_I <= {22'h0, ix, 2'h0};
        HWRITE_I <= w;
        HTRANS_I <= 2'h2;
        if (!w) q_rd.push_back(e);
        @(posedge CLK_I);
        while (!HREADYOUT_O) @(posedge CLK_I);
        HSEL_I <= 0;
        HTRANS_I <= 2'h0;
        HWDATA_I <= d;
        rd_ph <= !w;
        @(posedge CLK_I);
        while (!HREADYOUT_O) @(posedge CLK_I);
        rd_ph <= 0;
    endtask

    task wr(input logic [7:0] ix, input logic [15:0] d); ahb(1, ix, {16'h0, d}, 0); endtask
    task rd(input logic [7:0] ix, input logic [15:0] e); ahb(0, ix, 0, {16'h0, e}); endtask

    task pins(input logic [3:0] e);
        repeat (3) @(posedge CLK_I);
        q_pin.push_back(e);
        pin_pr <= 1;
        @(posedge CLK_I);
        pin_pr <= 0;
    endtask

    task mods(input int n, input logic b);
        repeat (n) begin
            MOD_STB_I <= 1;
            MOD_BIT_I <= b;
            @(posedge CLK_I);
        end
        MOD_STB_I <= 0;
        repeat (12) @(posedge CLK_I);
    endtask

    function logic [23:0] cal(input logic [23:0] r, input logic [23:0] o, input logic [15:0] g);
        longint p;
        p = (longint'($signed(r)) - longint'($signed(o))) * (65536 + longint'($signed(g)));
        p = p >>> 16;
        return (p > 8388607) ? 24'h7FFFFF : (p < -8388608) ? 24'h800000 : p[23:0];
    endfunction

    task raw(input logic [23:0] d, input logic [23:0] o, input logic [15:0] g);
        RAW_VLD_I <= 1;
        RAW_DATA_I <= d;
        q_cal.push_back(cal(d, o, g));
        @(posedge CLK_I);
    endtask

    initial begin
        logic [15:0] gl [4];
        logic [15:0] oh;
        logic [7:0]  ol;
        logic [23:0] d;
        gl = '{16'h0000, 16'h7FFF, 16'h8000, 16'h0000};
        oh = $urandom(82141);
        repeat (5) @(posedge CLK_I);
        RSTN_I <= 1;
        @(posedge CLK_I);
        while (!HREADYOUT_O) @(posedge CLK_I);
        rd(8'hC4, 0); rd(8'hC5, 0); rd(8'hC6, 0); rd(8'hC7, 0);
        rd(8'hC8, 16'h7FFF); rd(8'hC9, 16'h8000); rd(8'h40, 0);
        $display("test 1 done");
        wr(8'hC4, oh); rd(8'hC4, oh); wr(8'hC5, 16'hFFFF); rd(8'hC5, 16'hFF00);
        wr(8'hC7, 16'h5FFF); rd(8'hC7, 16'h5F00); wr(8'h40, 16'hFFFF); rd(8'h40, 0);
        $display("test 2 done");
        gl[3] = $urandom;
        for (int i = 0; i < 4; i++) begin
            oh = $urandom;
            ol = $urandom;
            d = $urandom;
            wr(8'hC4, oh); wr(8'hC5, {ol, 8'h00}); wr(8'hC6, gl[i]); rd(8'hC6, gl[i]);
            raw(d, {oh, ol}, gl[i]); raw(~d, {oh, ol}, gl[i]);
            RAW_VLD_I <= 0;
            @(posedge CLK_I);
        end
        wr(8'hC4, 16'h8000); wr(8'hC5, 0); wr(8'hC6, 16'h7FFF);
        raw(24'h7FFFFF, 24'h800000, 16'h7FFF);
        RAW_VLD_I <= 0;
        @(posedge CLK_I);
        $display("test 3 done");
        wr(8'hC8, 16'h0100); wr(8'hC9, 16'hFF00); wr(8'hD1, 3); wr(8'hD2, 1);
        wr(8'hC7, 16'hDF00); mods(64 * 20, 1); rd(8'hD0, 0); pins(4'b0010);
        wr(8'hC7, 16'hC000); mods(64 * 6, 1); rd(8'hD0, 1); pins(4'b1111);
        wr(8'hD1, 0); pins(4'b1110); wr(8'hD1, 3);
        wr(8'hC7, 0); wr(8'hD0, 1); rd(8'hD0, 0);
        wr(8'hC7, 16'h8000); wr(8'hD2, 3); mods(64 * 6, 0); rd(8'hD0, 2); pins(4'b0011);
        wr(8'hC7, 0); wr(8'hD0, 2); pins(4'b1100);
        $display("test 4 done");
        close_out;
    end
endmodule // actocf_top_tb
